// ===== src/pic_pkg.sv
package pic_pkg;
  // register offsets (byte addresses = index * 4)
  localparam logic [7:0] IDX_POWER_CONTROL  = 8'h08;
  localparam logic [7:0] IDX_CHANGE_WAKE    = 8'h09;
  localparam logic [7:0] IDX_PC_HIGH_BUFFER = 8'h0A;
  localparam logic [7:0] IDX_PULLDOWN       = 8'h0B;
  localparam logic [7:0] IDX_OPENDRAIN      = 8'h0C;
  localparam logic [7:0] IDX_PULLUP         = 8'h0D;
  localparam logic [7:0] IDX_IRQ_ENABLE     = 8'h0E;
  localparam logic [7:0] IDX_IRQ_FLAGS      = 8'h0F;
  // extra control/status words
  localparam logic [7:0] IDX_CORE_CTRL      = 8'h10;
  localparam logic [7:0] IDX_PIN_STATUS     = 8'h11;
  // field positions
  localparam int BIT_ROPT  = 4;
  localparam int BIT_LVD   = 5;
  localparam int BIT_XSEL  = 6;
  localparam int BIT_WDOG  = 7;
  localparam int BIT_TMR   = 0;
  localparam int BIT_PBC   = 1;
  localparam int BIT_EXT   = 2;
  localparam int BIT_GLB   = 7;
  localparam int BIT_EDGE  = 0;
  // read masks
  localparam logic [7:0] MASK_POWER   = 8'hF0;
  localparam logic [7:0] MASK_ENABLE  = 8'h87;
  localparam logic [7:0] MASK_FLAGS   = 8'h07;
  // reset values
  localparam logic [7:0] RST_POWER    = 8'h00;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_ONES     = 8'hFF;
  localparam logic       RST_EDGE     = 1'b0;
  localparam logic [31:0] RST_RDATA   = 32'h0000_0000;
endpackage

// ===== src/pic_regs.sv
// Functional notes
// - power_control bits 3:0 read zero.
// - resistor_option_on makes port A pins 0,1 report external resistor presence.
// - power_control bit 5 enables the low voltage detector.
// - ext_irq_pin_select zero blocks the external interrupt path of port B pin 0.
// - external interrupt selection blocks pin 0 change path.
// - port B data bit 0 still shows the external interrupt pin level.
// - power_control bit 7 enables the watchdog timer.
// - change_wake_enables bit n enables change interrupt and wake of pin n.
// - pc_high_buffer holds upper pc bits, width per variant.
// - pulldown_control active low, bits 3:0 port A, 7:4 port B.
// - opendrain_control bit n enables open drain on port B pin n.
// - pullup_control bit n active low enables pull-high on port B pin n.
// - interrupt_enable bits 0,1,2,7; bits 6:3 read zero.
// - wake with global enable zero resumes after the sleep instruction.
// - wake with global enable one branches to interrupt address.
// - taken interrupt clears the global enable.
// - return_from_interrupt sets the global enable again.
// - flag bit 0 sets on timer overflow, held until cleared.
// - flag bit 1 sets on enabled port B change, held until cleared.
// - flag bit 2 sets on selected external pin edge.
// - interrupt_flags bits 7:3 read zero.
// - working_operand is not reachable at any data address.
// - edge select one means rising, zero falling.
// - pull resistors off while the pin is an output.
//
// Local design decision: the APB slave port.
module pic_regs #(
  parameter int PC_HIGH_BITS = 3
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_overflow,
  input  wire logic [7:0]  port_b_pins,
  input  wire logic [1:0]  port_a_r_sense,
  input  wire logic [7:0]  port_b_dir,
  input  wire logic [3:0]  port_a_dir,
  input  wire logic        ext_pin_edge_select,
  input  wire logic        sleeping,
  input  wire logic        return_from_interrupt,
  input  wire logic        operand_load,
  input  wire logic [7:0]  operand_data,
  output logic             watchdog_on_bit,
  output logic             low_voltage_detect_on,
  output logic             resistor_option_on,
  output logic             ext_irq_pin_select,
  output logic [2:0]       pc_high,
  output logic [7:0]       port_b_pullup_on,
  output logic [7:0]       port_b_opendrain_on,
  output logic [3:0]       port_a_pulldown_on,
  output logic [3:0]       port_b_pulldown_on,
  output logic [1:0]       port_a_r_read,
  output logic [7:0]       port_b_data,
  output logic             irq_request,
  output logic             wake_request,
  output logic             wake_to_vector,
  output logic [7:0]       working_operand
);

  logic [7:0] power_control_r;
  logic [7:0] change_wake_enables_r;
  logic [2:0] pc_high_buffer_r;
  logic [7:0] pulldown_control_r;
  logic [7:0] opendrain_control_r;
  logic [7:0] pullup_control_r;
  logic [7:0] interrupt_enable_r;
  logic [7:0] interrupt_flags_r;
  logic       edge_sel_r;
  logic [7:0] pins_prev_r;
  logic [7:0] working_operand_r;
  logic [7:0] rd_nxt;
  logic       mapped;
  logic [7:0] idx;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] wbyte;
  logic [7:0] change_mask;
  logic       pb_change;
  logic       ext_edge;
  logic [2:0] flag_set;
  logic [2:0] pending;
  logic       irq_take;
  logic [2:0] pc_mask;

  assign idx   = paddr[9:2];
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_en = psel && !penable && !pwrite;
  assign wbyte = pwdata[7:0];
  assign pc_mask = 3'((4'h1 << PC_HIGH_BITS) - 4'h1);

  // address decode; working_operand has no address
  always_comb begin
    rd_nxt = 8'h00;
    mapped = 1'b1;
    if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end else if (idx == pic_pkg::IDX_POWER_CONTROL) begin
      rd_nxt = power_control_r & pic_pkg::MASK_POWER;
    end else if (idx == pic_pkg::IDX_CHANGE_WAKE) begin
      rd_nxt = change_wake_enables_r;
    end else if (idx == pic_pkg::IDX_PC_HIGH_BUFFER) begin
      rd_nxt = {5'h00, pc_high_buffer_r};
    end else if (idx == pic_pkg::IDX_PULLDOWN) begin
      rd_nxt = pulldown_control_r;
    end else if (idx == pic_pkg::IDX_OPENDRAIN) begin
      rd_nxt = opendrain_control_r;
    end else if (idx == pic_pkg::IDX_PULLUP) begin
      rd_nxt = pullup_control_r;
    end else if (idx == pic_pkg::IDX_IRQ_ENABLE) begin
      rd_nxt = interrupt_enable_r & pic_pkg::MASK_ENABLE;
    end else if (idx == pic_pkg::IDX_IRQ_FLAGS) begin
      rd_nxt = interrupt_flags_r & pic_pkg::MASK_FLAGS;
    end else if (idx == pic_pkg::IDX_CORE_CTRL) begin
      rd_nxt = {7'h00, edge_sel_r};
    end else if (idx == pic_pkg::IDX_PIN_STATUS) begin
      rd_nxt = port_b_pins;
    end else begin
      mapped = 1'b0;
    end
  end

  // pin change and edge detection
  assign change_mask = change_wake_enables_r
                     & ~{7'h00, power_control_r[pic_pkg::BIT_XSEL]};
  assign pb_change = |((port_b_pins ^ pins_prev_r) & change_mask);
  assign ext_edge = power_control_r[pic_pkg::BIT_XSEL]
                  && (edge_sel_r ? (port_b_pins[0] && !pins_prev_r[0])
                                 : (!port_b_pins[0] && pins_prev_r[0]));
  assign flag_set = {ext_edge, pb_change, timer_overflow};
  assign pending = interrupt_flags_r[2:0] & interrupt_enable_r[2:0];
  assign irq_take = interrupt_enable_r[pic_pkg::BIT_GLB] && (|pending);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_prev_r <= pic_pkg::RST_ZERO;
    end else begin
      pins_prev_r <= port_b_pins;
    end
  end

  // apb answer: zero wait states, error on unmapped word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= pic_pkg::RST_RDATA;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd_en) begin
        prdata <= {24'h000000, rd_nxt};
      end
    end
  end

  logic xfer_ok;
  assign xfer_ok = psel && penable && pready && !pslverr;
  logic wr_ok;
  assign wr_ok = wr_en && xfer_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control_r <= pic_pkg::RST_POWER;
    end else if (wr_ok && idx == pic_pkg::IDX_POWER_CONTROL) begin
      power_control_r <= wbyte & pic_pkg::MASK_POWER;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_wake_enables_r <= pic_pkg::RST_ZERO;
    end else if (wr_ok && idx == pic_pkg::IDX_CHANGE_WAKE) begin
      change_wake_enables_r <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_high_buffer_r <= 3'h0;
    end else if (wr_ok && idx == pic_pkg::IDX_PC_HIGH_BUFFER) begin
      pc_high_buffer_r <= wbyte[2:0] & pc_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulldown_control_r <= pic_pkg::RST_ONES;
    end else if (wr_ok && idx == pic_pkg::IDX_PULLDOWN) begin
      pulldown_control_r <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opendrain_control_r <= pic_pkg::RST_ZERO;
    end else if (wr_ok && idx == pic_pkg::IDX_OPENDRAIN) begin
      opendrain_control_r <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_control_r <= pic_pkg::RST_ONES;
    end else if (wr_ok && idx == pic_pkg::IDX_PULLUP) begin
      pullup_control_r <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_sel_r <= pic_pkg::RST_EDGE;
    end else if (wr_ok && idx == pic_pkg::IDX_CORE_CTRL) begin
      edge_sel_r <= wbyte[pic_pkg::BIT_EDGE];
    end
  end

  // interrupt enable with hardware global clear / set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_r <= pic_pkg::RST_ZERO;
    end else begin
      if (wr_ok && idx == pic_pkg::IDX_IRQ_ENABLE) begin
        interrupt_enable_r <= wbyte & pic_pkg::MASK_ENABLE;
      end
      if (return_from_interrupt) begin
        interrupt_enable_r[pic_pkg::BIT_GLB] <= 1'b1;
      end else if (irq_take) begin
        interrupt_enable_r[pic_pkg::BIT_GLB] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_flags_r <= pic_pkg::RST_ZERO;
    end else if (wr_ok && idx == pic_pkg::IDX_IRQ_FLAGS) begin
      interrupt_flags_r <= (wbyte & pic_pkg::MASK_FLAGS) | {5'h00, flag_set};
    end else begin
      interrupt_flags_r <= interrupt_flags_r | {5'h00, flag_set};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_operand_r <= pic_pkg::RST_ZERO;
    end else if (operand_load) begin
      working_operand_r <= operand_data;
    end
  end

  // registered control outputs, one flop group per concern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_on_bit <= 1'b0;
    end else begin
      watchdog_on_bit <= power_control_r[pic_pkg::BIT_WDOG];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_voltage_detect_on <= 1'b0;
    end else begin
      low_voltage_detect_on <= power_control_r[pic_pkg::BIT_LVD];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resistor_option_on <= 1'b0;
    end else begin
      resistor_option_on <= power_control_r[pic_pkg::BIT_ROPT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_pin_select <= 1'b0;
    end else begin
      ext_irq_pin_select <= power_control_r[pic_pkg::BIT_XSEL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_high <= 3'h0;
    end else begin
      pc_high <= pc_high_buffer_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_pullup_on <= 8'h00;
    end else begin
      port_b_pullup_on <= ~pullup_control_r & port_b_dir;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_opendrain_on <= 8'h00;
    end else begin
      port_b_opendrain_on <= opendrain_control_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_pulldown_on <= 4'h0;
    end else begin
      port_a_pulldown_on <= ~pulldown_control_r[3:0] & port_a_dir;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_pulldown_on <= 4'h0;
    end else begin
      port_b_pulldown_on <= ~pulldown_control_r[7:4] & port_b_dir[3:0];
    end
  end

  // resistor present to ground reads zero, absent reads one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_r_read <= 2'h0;
    end else begin
      port_a_r_read <= power_control_r[pic_pkg::BIT_ROPT] ? ~port_a_r_sense : 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_data <= 8'h00;
    end else begin
      port_b_data <= port_b_pins;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= interrupt_enable_r[pic_pkg::BIT_GLB] && (|pending);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= sleeping && (|pending);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_to_vector <= 1'b0;
    end else begin
      wake_to_vector <= sleeping && (|pending) && interrupt_enable_r[pic_pkg::BIT_GLB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_operand <= 8'h00;
    end else begin
      working_operand <= working_operand_r;
    end
  end

endmodule

// ===== dv/pic_regs_monitor.sv
module pic_regs_monitor #(
  parameter int PC_HIGH_BITS = 3
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  port_a_dir,
  input wire logic [7:0]  port_b_dir,
  input wire logic        watchdog_on_bit,
  input wire logic        low_voltage_detect_on,
  input wire logic        resistor_option_on,
  input wire logic [1:0]  port_a_r_read,
  input wire logic [3:0]  port_a_pulldown_on,
  input wire logic [3:0]  port_b_pulldown_on,
  input wire logic [7:0]  port_b_pullup_on,
  input wire logic [7:0]  port_b_opendrain_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = psel & penable & pready & pwrite & pstrb[0];
  assign rd_ok = psel & penable & pready & !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  AST_PWR_LOW:
    assert property (rd_ok && paddr == 12'h020 |-> prdata[3:0] == 4'h0) else $error("power low bits set");
  AST_EN_GAP:
    assert property (rd_ok && paddr == 12'h038 |-> prdata[6:3] == 4'h0) else $error("enable gap bits set");
  AST_FLG_GAP:
    assert property (rd_ok && paddr == 12'h03C |-> prdata[7:3] == 5'h00) else $error("flag gap bits set");
  AST_UNMAPPED:
    assert property (rd_ok && paddr == 12'h080 |-> pslverr && prdata == 32'h0) else $error("unmapped read");
  AST_WDOG:
    assert property (wr_ok && paddr == 12'h020 |-> ##2 watchdog_on_bit == $past(pwdata[7], 2)) else $error("watchdog");
  AST_LVD:
    assert property (wr_ok && paddr == 12'h020 |-> ##2 low_voltage_detect_on == $past(pwdata[5], 2)) else $error("lvd");
  AST_ODR:
    assert property (wr_ok && paddr == 12'h030 |-> ##2 port_b_opendrain_on == $past(pwdata[7:0], 2)) else $error("od");
  AST_PDN:
    assert property (wr_ok && paddr == 12'h02C && port_a_dir == 4'hF |-> ##2
      ($past(port_a_dir) != 4'hF || port_a_pulldown_on == ~$past(pwdata[3:0], 2))) else $error("pulldown");
  AST_GATE:
    assert property (port_b_dir == 8'h00 && $past(port_b_dir) == 8'h00 |->
      port_b_pullup_on == 8'h00 && port_b_pulldown_on == 4'h0) else $error("pull on output pin");
  AST_ROPT_OFF:
    assert property (!resistor_option_on && !$past(resistor_option_on) |-> port_a_r_read == 2'b00) else $error("ropt");
endmodule

bind pic_regs pic_regs_monitor #(.PC_HIGH_BITS(PC_HIGH_BITS)) u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .port_a_dir, .port_b_dir, .watchdog_on_bit,
  .low_voltage_detect_on, .resistor_option_on, .port_a_r_read, .port_a_pulldown_on, .port_b_pulldown_on,
  .port_b_pullup_on, .port_b_opendrain_on);

// ===== dv/pic_pins_model.sv
module pic_pins_model (
  input  wire logic       pclk,
  input  wire logic       ext_sel,
  input  wire logic [7:0] level,
  input  wire logic [7:0] dir_req,
  output logic      [7:0] port_b_pins,
  output logic      [7:0] port_b_dir
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge pclk) begin
    port_b_pins <= level;
  end
  // firmware turns pin 0 into an input whenever the external pin is chosen
  always_comb begin
    port_b_dir    = dir_req;
    port_b_dir[0] = dir_req[0] | ext_sel;
  end
endmodule

// ===== dv/pic_regs_tb.sv
module pic_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tmr = 0, rfi = 0, opl = 0, slp = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, seed = 32'h9BA0E90B;
  logic [3:0]  pstrb = 4'hF, port_a_dir = 4'hF, apd, bpd;
  logic        pready, pslverr, wdog, lvd, ropt, extsel, irq, err, wrq, wtv;
  logic [7:0]  lev = 0, dreq = 0, opd = 0, pins, bdir, pu, od, bdat, wop, q;
  logic [2:0]  pch;
  logic [1:0]  sense = 2'b01, rr;
  int          num_errors = 0, tests_run = 0, cyc = 0, irq_cnt = 0, wtv_cnt = 0, base = 0;
  initial forever #5 pclk = ~pclk;
  pic_pins_model i_pins (.pclk(pclk), .ext_sel(extsel), .level(lev), .dir_req(dreq), .port_b_pins(pins),
    .port_b_dir(bdir));
  pic_regs #(.PC_HIGH_BITS(3)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_overflow(tmr), .port_b_pins(pins), .port_a_r_sense(sense), .port_b_dir(bdir), .port_a_dir(port_a_dir),
    .ext_pin_edge_select(1'b0), .sleeping(slp), .return_from_interrupt(rfi), .operand_load(opl),
    .operand_data(opd), .watchdog_on_bit(wdog), .low_voltage_detect_on(lvd), .resistor_option_on(ropt),
    .ext_irq_pin_select(extsel), .pc_high(pch), .port_b_pullup_on(pu), .port_b_opendrain_on(od),
    .port_a_pulldown_on(apd), .port_b_pulldown_on(bpd), .port_a_r_read(rr), .port_b_data(bdat),
    .irq_request(irq), .wake_request(wrq), .wake_to_vector(wtv), .working_operand(wop));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] msk(input int i);
    return (i == 0) ? 8'hF0 : (i == 2) ? 8'h07 : 8'hFF;
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
    apb(0, a, 8'h00);
    `CHK(n, e, q)
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (wtv === 1'b1) wtv_cnt <= wtv_cnt + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 8; i++) rd(12'(12'h020 + 4 * i), (i == 3 || i == 5) ? 8'hFF : 8'h00, "reset");
    for (int k = 0; k < 24; k++) begin
      seed = xs(seed);
      apb(1, 12'(12'h020 + 4 * (k % 6)), seed[7:0]);
      rd(12'(12'h020 + 4 * (k % 6)), seed[7:0] & msk(k % 6), "readback");
      if (k % 6 == 2) `CHK("pc_high", seed[2:0], pch)
    end
    $display("random readback done");
    apb(1, 12'h020, 8'h00);
    dreq <= 8'hFF;
    apb(1, 12'h02C, 8'h5A);
    pstrb <= 4'h0;
    apb(1, 12'h02C, 8'hA5);
    pstrb <= 4'hF;
    rd(12'h02C, 8'h5A, "strobe");
    `CHK("pulldown", 8'hA5, {bpd, apd})
    apb(1, 12'h034, 8'h0F);
    repeat (2) @(posedge pclk);
    `CHK("pullup", 8'hF0, pu)
    rd(12'h080, 8'h00, "unmapped");
    `CHK("slverr", 1'b1, err)
    opd <= seed[15:8];
    opl <= 1;
    @(posedge pclk);
    opl <= 0;
    repeat (2) @(posedge pclk);
    `CHK("operand", seed[15:8], wop)
    apb(1, 12'h020, 8'h10);
    repeat (2) @(posedge pclk);
    `CHK("r_read", ~sense, rr)
    apb(1, 12'h020, 8'h00);
    $display("access checks done");
    apb(1, 12'h03C, 8'h00);
    tmr <= 1;
    @(posedge pclk);
    tmr <= 0;
    rd(12'h03C, 8'h01, "timer flag");
    rd(12'h03C, 8'h01, "timer held");
    apb(1, 12'h03C, 8'h00);
    rd(12'h03C, 8'h00, "flag clear");
    apb(1, 12'h024, 8'h08);
    lev <= 8'h08;
    repeat (4) @(posedge pclk);
    rd(12'h03C, 8'h02, "change");
    apb(1, 12'h03C, 8'h00);
    lev <= 8'h18;
    repeat (4) @(posedge pclk);
    rd(12'h03C, 8'h00, "masked change");
    apb(1, 12'h020, 8'h40);
    apb(1, 12'h040, 8'h01);
    apb(1, 12'h024, 8'h01);
    lev <= 8'h19;
    repeat (4) @(posedge pclk);
    rd(12'h03C, 8'h04, "ext rise");
    `CHK("pin0 read", 1'b1, bdat[0])
    apb(1, 12'h03C, 8'h00);
    lev <= 8'h18;
    repeat (4) @(posedge pclk);
    rd(12'h03C, 8'h00, "ext fall");
    apb(1, 12'h020, 8'h00);
    lev <= 8'h19;
    repeat (4) @(posedge pclk);
    rd(12'h03C, 8'h02, "pin0 plain");
    $display("flag sources done");
    apb(1, 12'h024, 8'h00);
    apb(1, 12'h03C, 8'h00);
    apb(1, 12'h038, 8'h01);
    base = irq_cnt;
    tmr <= 1;
    @(posedge pclk);
    tmr <= 0;
    repeat (4) @(posedge pclk);
    `CHK("irq no global", 0, irq_cnt - base)
    apb(1, 12'h038, 8'h81);
    repeat (3) @(posedge pclk);
    `CHK("irq", 1, irq_cnt - base)
    rd(12'h038, 8'h01, "global cleared");
    apb(1, 12'h03C, 8'h00);
    rfi <= 1;
    @(posedge pclk);
    rfi <= 0;
    rd(12'h038, 8'h81, "global back");
    apb(1, 12'h038, 8'h01);
    slp <= 1;
    tmr <= 1;
    @(posedge pclk);
    tmr <= 0;
    repeat (3) @(posedge pclk);
    `CHK("wake resume", 2'b10, {wrq, wtv})
    apb(1, 12'h03C, 8'h00);
    apb(1, 12'h038, 8'h81);
    base = wtv_cnt;
    tmr <= 1;
    @(posedge pclk);
    tmr <= 0;
    repeat (3) @(posedge pclk);
    `CHK("wake vector", 1, wtv_cnt - base)
    slp <= 0;
    $display("interrupt checks done");
    end_of_test();
  end
endmodule
